// >>> rtl/psab_pkg.sv
// Package of command codes, bit layouts and defaults for the status bank
package psab_pkg;

  typedef logic [7:0] psab_byte_t;

  // Command codes that select a status register
  localparam psab_byte_t CMD_VOUT = 8'h7A;
  localparam psab_byte_t CMD_IOUT = 8'h7B;
  localparam psab_byte_t CMD_INPUT = 8'h7C;
  localparam psab_byte_t CMD_TEMP = 8'h7D;
  localparam psab_byte_t CMD_COMM_MEM = 8'h7E;
  localparam psab_byte_t CMD_MFR = 8'h80;
  localparam psab_byte_t CMD_PADS = 8'hE5;
  localparam psab_byte_t CMD_COMMON = 8'hEF;

  // Implemented bits of each status byte
  localparam psab_byte_t SUP_VOUT = 8'hFE;
  localparam psab_byte_t SUP_IOUT = 8'hA0;
  localparam psab_byte_t SUP_INPUT = 8'hAA;
  localparam psab_byte_t SUP_TEMP = 8'hD0;
  localparam psab_byte_t SUP_COMM_MEM = 8'hFB;
  localparam psab_byte_t SUP_MFR_SHARED = 8'hFE;
  localparam psab_byte_t SUP_MFR_PAGE = 8'h01;

  // Bits that may raise alert and bits that a one-write clears
  localparam psab_byte_t ALERT_INPUT = 8'h80;
  localparam psab_byte_t W1C_INPUT = 8'h80;
  localparam psab_byte_t W1C_MFR_SHARED = 8'hF6;

  // Position of the fault-log-present bit in the vendor byte
  localparam int MFR_LOG_BIT = 3;

  // Alert mask values after reset
  localparam psab_byte_t MASK_RST_NONE = 8'h00;
  localparam psab_byte_t MASK_RST_MFR_SHARED = 8'h10;
  localparam psab_byte_t MASK_RST_MFR_PAGE = 8'h01;

  // Values after reset
  localparam psab_byte_t STATUS_RST = 8'h00;
  localparam logic [15:0] READ_RST = 16'h0000;

  localparam int NUM_PAGES = 2;

  // Per-channel fault condition pulses or levels, same clock
  typedef struct packed {
    psab_byte_t voutSet;
    psab_byte_t ioutSet;
    psab_byte_t tempSet;
    logic gpioPulledLow;
  } psab_page_cond_s;

  // Device-wide fault conditions, same clock
  typedef struct packed {
    psab_byte_t inputSet;
    psab_byte_t commMemSet;
    psab_byte_t mfrSet;
  } psab_shared_cond_s;

  // Pad-state word, bit 15 first
  typedef struct packed {
    logic rail3v3Over;
    logic rail3v3Under;
    logic [1:0] reserved;
    logic adcInvalid;
    logic syncOutDisabled;
    logic channel1OutputGood;
    logic channel0OutputGood;
    logic drivingChannel1RunLow;
    logic drivingChannel0RunLow;
    logic channel1RunPin;
    logic channel0RunPin;
    logic drivingFault1Low;
    logic drivingFault0Low;
    logic channel1FaultPin;
    logic channel0FaultPin;
  } psab_pad_s;

  // Internal inputs of the common-state byte
  typedef struct packed {
    logic notBusy;
    logic calcNotPending;
    logic notInTransition;
    logic nvmInitialized;
    logic sharedTimebaseTimeout;
  } psab_common_s;

endpackage

// >>> rtl/psab_sync2.sv
// Two-flop synchroniser for pin levels
module psab_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] synced
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // First stage feeds only the second stage
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= async;
      sync_ff <= meta_ff;
    end
  end

  assign synced = sync_ff;

endmodule

// >>> rtl/psab_latch_byte.sv
// Latched status byte with one-write clear and alert mask
module psab_latch_byte
  import psab_pkg::*;
#(
  parameter psab_byte_t SUP = 8'hFF,
  parameter psab_byte_t ALERTABLE = 8'hFF,
  parameter psab_byte_t W1C = 8'hFF,
  parameter psab_byte_t MASK_RST = 8'h00
) (
  input wire logic clock,
  input wire logic reset,
  input wire psab_byte_t setIn,
  input wire logic w1cStrobe,
  input wire psab_byte_t w1cData,
  input wire psab_byte_t forceClr,
  input wire logic maskStrobe,
  input wire psab_byte_t maskData,
  output psab_byte_t status,
  output logic alertReq
);

  psab_byte_t status_ff;
  psab_byte_t mask_ff;
  psab_byte_t clrBits;
  psab_byte_t nxt_status;

  // Clear sources, then set wins over clear
  always_comb
  begin
    clrBits = forceClr
      | (w1cStrobe ? (w1cData & W1C) : STATUS_RST);
    nxt_status = ((status_ff & ~clrBits) | setIn) & SUP;
  end

  // Status latch
  always_ff @(posedge clock)
  begin
    if (reset)
      status_ff <= STATUS_RST;
    else
      status_ff <= nxt_status;
  end

  // Mask storage; only alert-capable bits are maskable
  always_ff @(posedge clock)
  begin
    if (reset)
      mask_ff <= MASK_RST;
    else if (maskStrobe)
      mask_ff <= maskData & SUP & ALERTABLE;
  end

  assign status = status_ff;
  assign alertReq = |(status_ff & ALERTABLE & ~mask_ff);

  a_set_latches: assert property (@(posedge clock) disable iff (reset)
    (setIn & SUP) != 8'h00 |=> (status_ff & $past(setIn & SUP))
      == $past(setIn & SUP))
    else $error("Detected condition did not latch");

  a_w1c_clears: assert property (@(posedge clock) disable iff (reset)
    w1cStrobe && (setIn == 8'h00) && (forceClr == 8'h00)
      |=> (status_ff & $past(w1cData & W1C)) == 8'h00)
    else $error("One-write did not clear the bit");

  a_unsup_zero: assert property (@(posedge clock) disable iff (reset)
    (status_ff & ~SUP) == 8'h00)
    else $error("Unsupported status bit is set");

  a_bit_holds: assert property (@(posedge clock) disable iff (reset)
    !w1cStrobe && (forceClr == 8'h00) |=> (status_ff & $past(status_ff))
      == $past(status_ff))
    else $error("Latched bit dropped without a clear");

endmodule

// >>> rtl/psab_status_bank.sv
// Status and alert register bank of a dual-channel power controller
// Operation
// - Voltage byte: OV/UV faults, warnings, timeouts; bit0 zero
// - Voltage bits 7 to 1 may raise alert
// - Writing one clears that voltage status bit
// - Current byte: fault bit7, warning bit5 only
// - Current, temperature, comm bits alert; one-write clears
// - Input byte: only bit7 alerts and clears
// - Temperature byte: bits 7, 6, 4 only
// - Comm/memory/logic byte layout, bit 2 zero
// - Vendor byte layout, bit7 down to bit0
// - Vendor byte shared; bit0 held per page
// - Any vendor bit sets summary bit
// - One-write clears vendor bits except fault log
// - Every vendor bit initiates alert
// - Read-only pad-state word of pin conditions
// - Read-only common-state byte layout
// - Fault bits maskable, alerting, clearable; dynamic not
// - Derived bits neither maskable nor clearable
// - Global clear clears all but fault-log bit and bits whose condition is still present; releases alert unless one of those is set
// - Per-register alert mask, bit aligned
// - Vendor mask defaults to bits 4 and 0
module psab_status_bank
  import psab_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire psab_byte_t cmdCode,
  input wire logic cmdPage,
  input wire logic writeStrobe,
  input wire psab_byte_t writeData,
  input wire logic maskStrobe,
  input wire psab_byte_t maskCode,
  input wire psab_byte_t maskData,
  input wire logic clearFaults,
  input wire logic faultLogClear,
  input wire psab_page_cond_s pageCond0,
  input wire psab_page_cond_s pageCond1,
  input wire psab_shared_cond_s sharedCond,
  input wire psab_pad_s padInternal,
  input wire logic [3:0] padPinsRaw,
  input wire logic writeProtectPinRaw,
  input wire psab_common_s commonIn,
  output logic [15:0] readData,
  output logic alertN,
  output logic [1:0] mfrSummary
);

  psab_page_cond_s pageCond [NUM_PAGES];
  psab_byte_t voutStatus [NUM_PAGES];
  psab_byte_t ioutStatus [NUM_PAGES];
  psab_byte_t tempStatus [NUM_PAGES];
  psab_byte_t mfrPageStatus [NUM_PAGES];
  logic [NUM_PAGES-1:0] voutAlert;
  logic [NUM_PAGES-1:0] ioutAlert;
  logic [NUM_PAGES-1:0] tempAlert;
  logic [NUM_PAGES-1:0] mfrPageAlert;
  psab_byte_t inputStatus;
  psab_byte_t commMemStatus;
  psab_byte_t mfrSharedStatus;
  logic inputAlert;
  logic commMemAlert;
  logic mfrSharedAlert;
  psab_byte_t globalClr;
  psab_byte_t mfrSharedClr;
  logic [4:0] pinsSynced;
  psab_pad_s padWord;
  psab_byte_t commonByte;
  logic anyAlert;
  logic [15:0] nxt_readData;
  logic [15:0] readData_ff;
  logic alertN_ff;
  logic [1:0] mfrSummary_ff;

  assign pageCond[0] = pageCond0;
  assign pageCond[1] = pageCond1;

  // Global clear wipes everything but the fault-log bit
  always_comb
  begin
    globalClr = clearFaults ? 8'hFF : STATUS_RST;
    mfrSharedClr = globalClr;
    mfrSharedClr[MFR_LOG_BIT] = faultLogClear;
  end

  // Per-channel status bytes
  for (genvar gp = 0; gp < NUM_PAGES; gp++)
  begin : gPage
    logic pageSel;
    assign pageSel = (cmdPage == 1'(gp));

    psab_latch_byte #(
      .SUP(SUP_VOUT),
      .ALERTABLE(SUP_VOUT),
      .W1C(SUP_VOUT),
      .MASK_RST(MASK_RST_NONE)
    ) uVout (
      .clock(clock),
      .reset(reset),
      .setIn(pageCond[gp].voutSet),
      .w1cStrobe(writeStrobe && pageSel && cmdCode == CMD_VOUT),
      .w1cData(writeData),
      .forceClr(globalClr),
      .maskStrobe(maskStrobe && pageSel && maskCode == CMD_VOUT),
      .maskData(maskData),
      .status(voutStatus[gp]),
      .alertReq(voutAlert[gp])
    );

    psab_latch_byte #(
      .SUP(SUP_IOUT),
      .ALERTABLE(SUP_IOUT),
      .W1C(SUP_IOUT),
      .MASK_RST(MASK_RST_NONE)
    ) uIout (
      .clock(clock),
      .reset(reset),
      .setIn(pageCond[gp].ioutSet),
      .w1cStrobe(writeStrobe && pageSel && cmdCode == CMD_IOUT),
      .w1cData(writeData),
      .forceClr(globalClr),
      .maskStrobe(maskStrobe && pageSel && maskCode == CMD_IOUT),
      .maskData(maskData),
      .status(ioutStatus[gp]),
      .alertReq(ioutAlert[gp])
    );

    psab_latch_byte #(
      .SUP(SUP_TEMP),
      .ALERTABLE(SUP_TEMP),
      .W1C(SUP_TEMP),
      .MASK_RST(MASK_RST_NONE)
    ) uTemp (
      .clock(clock),
      .reset(reset),
      .setIn(pageCond[gp].tempSet),
      .w1cStrobe(writeStrobe && pageSel && cmdCode == CMD_TEMP),
      .w1cData(writeData),
      .forceClr(globalClr),
      .maskStrobe(maskStrobe && pageSel && maskCode == CMD_TEMP),
      .maskData(maskData),
      .status(tempStatus[gp]),
      .alertReq(tempAlert[gp])
    );

    // Externally pulled-low fault pin, held per page
    psab_latch_byte #(
      .SUP(SUP_MFR_PAGE),
      .ALERTABLE(SUP_MFR_PAGE),
      .W1C(SUP_MFR_PAGE),
      .MASK_RST(MASK_RST_MFR_PAGE)
    ) uMfrPage (
      .clock(clock),
      .reset(reset),
      .setIn({7'h00, pageCond[gp].gpioPulledLow}),
      .w1cStrobe(writeStrobe && pageSel && cmdCode == CMD_MFR),
      .w1cData(writeData),
      .forceClr(globalClr),
      .maskStrobe(maskStrobe && pageSel && maskCode == CMD_MFR),
      .maskData(maskData),
      .status(mfrPageStatus[gp]),
      .alertReq(mfrPageAlert[gp])
    );
  end

  // Input supply byte: only the overvoltage fault alerts
  psab_latch_byte #(
    .SUP(SUP_INPUT),
    .ALERTABLE(ALERT_INPUT),
    .W1C(W1C_INPUT),
    .MASK_RST(MASK_RST_NONE)
  ) uInput (
    .clock(clock),
    .reset(reset),
    .setIn(sharedCond.inputSet),
    .w1cStrobe(writeStrobe && cmdCode == CMD_INPUT),
    .w1cData(writeData),
    .forceClr(globalClr),
    .maskStrobe(maskStrobe && maskCode == CMD_INPUT),
    .maskData(maskData),
    .status(inputStatus),
    .alertReq(inputAlert)
  );

  // Communication, memory and logic byte
  psab_latch_byte #(
    .SUP(SUP_COMM_MEM),
    .ALERTABLE(SUP_COMM_MEM),
    .W1C(SUP_COMM_MEM),
    .MASK_RST(MASK_RST_NONE)
  ) uCommMem (
    .clock(clock),
    .reset(reset),
    .setIn(sharedCond.commMemSet),
    .w1cStrobe(writeStrobe && cmdCode == CMD_COMM_MEM),
    .w1cData(writeData),
    .forceClr(globalClr),
    .maskStrobe(maskStrobe && maskCode == CMD_COMM_MEM),
    .maskData(maskData),
    .status(commMemStatus),
    .alertReq(commMemAlert)
  );

  // Vendor byte bits 7 to 1, one copy for both pages
  psab_latch_byte #(
    .SUP(SUP_MFR_SHARED),
    .ALERTABLE(SUP_MFR_SHARED),
    .W1C(W1C_MFR_SHARED),
    .MASK_RST(MASK_RST_MFR_SHARED)
  ) uMfrShared (
    .clock(clock),
    .reset(reset),
    .setIn(sharedCond.mfrSet),
    .w1cStrobe(writeStrobe && cmdCode == CMD_MFR),
    .w1cData(writeData),
    .forceClr(mfrSharedClr),
    .maskStrobe(maskStrobe && maskCode == CMD_MFR),
    .maskData(maskData),
    .status(mfrSharedStatus),
    .alertReq(mfrSharedAlert)
  );

  // Pin levels from outside cross into the core clock
  psab_sync2 #(
    .WIDTH(5)
  ) uPinSync (
    .clock(clock),
    .reset(reset),
    .async({writeProtectPinRaw, padPinsRaw}),
    .synced(pinsSynced)
  );

  // Pad-state word: internal states plus synchronised pin levels
  always_comb
  begin
    padWord = padInternal;
    padWord.reserved = 2'h0;
    padWord.channel1RunPin = pinsSynced[3];
    padWord.channel0RunPin = pinsSynced[2];
    padWord.channel1FaultPin = pinsSynced[1];
    padWord.channel0FaultPin = pinsSynced[0];
  end

  // Common-state byte, dynamic, never latched nor masked
  assign commonByte = {alertN_ff, commonIn.notBusy, commonIn.calcNotPending,
    commonIn.notInTransition, commonIn.nvmInitialized, 1'b0,
    commonIn.sharedTimebaseTimeout, pinsSynced[4]};

  // Any unmasked alert-capable bit pulls alert
  assign anyAlert = (|voutAlert) | (|ioutAlert) | (|tempAlert)
    | (|mfrPageAlert) | inputAlert | commMemAlert | mfrSharedAlert;

  // Read selection by command code and page; unmapped reads zero
  always_comb
  begin
    nxt_readData = READ_RST;
    unique case (cmdCode)
      CMD_VOUT: nxt_readData[7:0] = voutStatus[cmdPage];
      CMD_IOUT: nxt_readData[7:0] = ioutStatus[cmdPage];
      CMD_INPUT: nxt_readData[7:0] = inputStatus;
      CMD_TEMP: nxt_readData[7:0] = tempStatus[cmdPage];
      CMD_COMM_MEM: nxt_readData[7:0] = commMemStatus;
      CMD_MFR: nxt_readData[7:0] = mfrSharedStatus | mfrPageStatus[cmdPage];
      CMD_PADS: nxt_readData = padWord;
      CMD_COMMON: nxt_readData[7:0] = commonByte;
      default: nxt_readData = READ_RST;
    endcase
  end

  // Registered read data
  always_ff @(posedge clock)
  begin
    if (reset)
      readData_ff <= READ_RST;
    else
      readData_ff <= nxt_readData;
  end

  // Alert pin, low while asserted
  always_ff @(posedge clock)
  begin
    if (reset)
      alertN_ff <= 1'b1;
    else
      alertN_ff <= ~anyAlert;
  end

  // Vendor summary bit per page, derived only
  always_ff @(posedge clock)
  begin
    if (reset)
      mfrSummary_ff <= 2'h0;
    else
    begin
      mfrSummary_ff[0] <= |(mfrSharedStatus | mfrPageStatus[0]);
      mfrSummary_ff[1] <= |(mfrSharedStatus | mfrPageStatus[1]);
    end
  end

  assign readData = readData_ff;
  assign alertN = alertN_ff;
  assign mfrSummary = mfrSummary_ff;

  // Bank-level checks on alert, clear, summary and read path
  a_alert_follows: assert property (@(posedge clock)
    disable iff (reset)
    anyAlert |=> !alertN_ff)
    else $error("Alert not asserted for an unmasked status bit");

  a_clear_releases: assert property (@(posedge clock)
    disable iff (reset)
    clearFaults && pageCond0 == '0 && pageCond1 == '0 && sharedCond == '0
      && (!mfrSharedStatus[MFR_LOG_BIT] || faultLogClear)
      |=> ##1 alertN_ff)
    else $error("Global clear with no fault did not release alert");

  a_vout_bit0: assert property (@(posedge clock) disable iff (reset)
    voutStatus[0][0] == 1'b0 && voutStatus[1][0] == 1'b0)
    else $error("Voltage status bit 0 is not zero");

  a_log_bit_kept: assert property (@(posedge clock)
    disable iff (reset)
    mfrSharedStatus[MFR_LOG_BIT] && !faultLogClear
      |=> mfrSharedStatus[MFR_LOG_BIT])
    else $error("Fault log bit cleared by other than its command");

  a_summary_tracks: assert property (@(posedge clock)
    disable iff (reset)
    (mfrSharedStatus | mfrPageStatus[0]) != 8'h00 |=> mfrSummary_ff[0])
    else $error("Vendor summary bit missing");

  a_common_alert: assert property (@(posedge clock)
    disable iff (reset)
    cmdCode == CMD_COMMON |=> readData_ff[7] == $past(alertN_ff))
    else $error("Common byte alert bit wrong");

  a_input_mask: assert property (@(posedge clock) disable iff (reset)
    (inputStatus & 8'h80) == 8'h00 |-> !inputAlert)
    else $error("Input byte alerted from a bit other than 7");

  a_summary_page1: assert property (@(posedge clock)
    disable iff (reset)
    (mfrSharedStatus | mfrPageStatus[1]) != 8'h00 |=> mfrSummary_ff[1])
    else $error("Vendor summary bit of page 1 missing");

  a_pad_read: assert property (@(posedge clock) disable iff (reset)
    cmdCode == CMD_PADS |=> readData_ff == $past(padWord))
    else $error("Pad-state word read back wrong");

  a_vendor_read: assert property (@(posedge clock) disable iff (reset)
    cmdCode == CMD_MFR |=> readData_ff[7:1] == $past(mfrSharedStatus[7:1]))
    else $error("Shared vendor bits differ between pages");

  a_common_fixed: assert property (@(posedge clock)
    disable iff (reset)
    cmdCode == CMD_COMMON |=> readData_ff[15:8] == 8'h00 && !readData_ff[2])
    else $error("Common byte reserved bits not zero");

endmodule

// >>> sim/psab_host_model.sv
// Host model that drives the register port of the status bank
module psab_host_model
  import psab_pkg::*;
(
  input wire logic clock,
  input wire logic [15:0] readData,
  output psab_byte_t cmdCode,
  output logic cmdPage,
  output logic writeStrobe,
  output psab_byte_t writeData,
  output logic maskStrobe,
  output psab_byte_t maskCode,
  output psab_byte_t maskData,
  output logic clearFaults,
  output logic faultLogClear
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle port at time zero
  initial
  begin
    {cmdCode, cmdPage, writeData, maskCode, maskData} = '0;
    {writeStrobe, maskStrobe, clearFaults, faultLogClear} = 4'h0;
  end

  // One strobed request: 0 write, 1 mask, 2 global clear, 3 log clear
  task automatic op(input int kind, input psab_byte_t code,
                    input logic page, input psab_byte_t data);
    @(posedge clock);
    cmdCode <= code;
    cmdPage <= page;
    writeData <= data;
    maskCode <= code;
    maskData <= data;
    writeStrobe <= (kind == 0);
    maskStrobe <= (kind == 1);
    clearFaults <= (kind == 2);
    faultLogClear <= (kind == 3);
    @(posedge clock);
    {writeStrobe, maskStrobe, clearFaults, faultLogClear} <= 4'h0;
    repeat (2) @(posedge clock);
    #1;
  endtask

  // Select a register and take the registered answer once settled
  task automatic rd(input psab_byte_t code, input logic page,
                    output logic [15:0] data);
    @(posedge clock);
    cmdCode <= code;
    cmdPage <= page;
    repeat (2) @(posedge clock);
    #1;
    data = readData;
  endtask
endmodule

// >>> sim/psab_status_bank_tb.sv
// Self-checking testbench of the status and alert register bank
module psab_status_bank_tb
  import psab_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clock = 1'b0;
  logic reset = 1'b1;
  psab_page_cond_s pageCond0 = '0;
  psab_page_cond_s pageCond1 = '0;
  psab_shared_cond_s sharedCond = '0;
  psab_pad_s padInternal = 16'hFFFF;
  logic [3:0] padPinsRaw = 4'hA;
  logic writeProtectPinRaw = 1'b1;
  psab_common_s commonIn = 5'h1F;
  psab_byte_t cmdCode, writeData, maskCode, maskData;
  logic cmdPage, writeStrobe, maskStrobe, clearFaults, faultLogClear;
  logic [15:0] readData;
  logic alertN;
  logic [1:0] mfrSummary;
  int failures = 0;
  int checks = 0;
  int cycles = 0;

  // 25 MHz clock
  initial
  begin
    forever #20 clock = ~clock;
  end

  psab_host_model host (.clock(clock), .readData(readData),
    .cmdCode(cmdCode), .cmdPage(cmdPage), .writeStrobe(writeStrobe),
    .writeData(writeData), .maskStrobe(maskStrobe), .maskCode(maskCode),
    .maskData(maskData), .clearFaults(clearFaults),
    .faultLogClear(faultLogClear));

  psab_status_bank dut (.clock(clock), .reset(reset), .cmdCode(cmdCode),
    .cmdPage(cmdPage), .writeStrobe(writeStrobe), .writeData(writeData),
    .maskStrobe(maskStrobe), .maskCode(maskCode), .maskData(maskData),
    .clearFaults(clearFaults), .faultLogClear(faultLogClear),
    .pageCond0(pageCond0), .pageCond1(pageCond1), .sharedCond(sharedCond),
    .padInternal(padInternal), .padPinsRaw(padPinsRaw),
    .writeProtectPinRaw(writeProtectPinRaw), .commonIn(commonIn),
    .readData(readData), .alertN(alertN), .mfrSummary(mfrSummary));

  // Counts and verdict, then end of run
  task automatic complete_run();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Cuts a hang short
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      complete_run();
    end
  end

  // Compare of one result
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rdchk(input string what, input psab_byte_t code,
                       input logic page, input logic [15:0] exp);
    logic [15:0] got;
    host.rd(code, page, got);
    chk(what, exp, got);
  endtask

  task automatic alert(input logic exp);
    chk("alertN", {15'h0000, exp}, {15'h0000, alertN});
  endtask

  // Drives one condition level; code 0 means the paged pin bit
  task automatic setc(input psab_byte_t code, input logic page,
                      input psab_byte_t v);
    psab_page_cond_s pc;
    psab_shared_cond_s sc;
    pc = '0;
    sc = '0;
    case (code)
      CMD_VOUT: pc.voutSet = v;
      CMD_IOUT: pc.ioutSet = v;
      CMD_TEMP: pc.tempSet = v;
      CMD_INPUT: sc.inputSet = v;
      CMD_COMM_MEM: sc.commMemSet = v;
      CMD_MFR: sc.mfrSet = v;
      default: pc.gpioPulledLow = v[0];
    endcase
    @(posedge clock);
    pageCond0 <= page ? '0 : pc;
    pageCond1 <= page ? pc : '0;
    sharedCond <= sc;
    repeat (3) @(posedge clock);
    #1;
  endtask

  task automatic pulse(input psab_byte_t code, input logic page,
                       input psab_byte_t v);
    setc(code, page, v);
    setc(code, page, 8'h00);
  endtask

  task automatic t_reset();
    psab_byte_t codes[7] = '{CMD_VOUT, CMD_IOUT, CMD_INPUT, CMD_TEMP,
                             CMD_COMM_MEM, CMD_MFR, 8'h00};
    foreach (codes[i])
      rdchk("status after reset", codes[i], 1'b0, 16'h0000);
    alert(1'b1);
    chk("mfrSummary", 16'h0000, {14'h0000, mfrSummary});
    $display("test reset done");
  endtask

  task automatic t_vout();
    pulse(CMD_VOUT, 1'b0, 8'hFF);
    rdchk("voltage page0", CMD_VOUT, 1'b0, 16'h00FE);
    rdchk("voltage page1", CMD_VOUT, 1'b1, 16'h0000);
    alert(1'b0);
    host.op(0, CMD_VOUT, 1'b0, 8'h81);
    rdchk("voltage one-write", CMD_VOUT, 1'b0, 16'h007E);
    host.op(0, CMD_VOUT, 1'b0, 8'h00);
    rdchk("voltage zero-write", CMD_VOUT, 1'b0, 16'h007E);
    host.op(0, CMD_VOUT, 1'b0, 8'h7E);
    rdchk("voltage cleared", CMD_VOUT, 1'b0, 16'h0000);
    alert(1'b1);
    $display("test voltage done");
  endtask

  task automatic t_bytes();
    psab_byte_t codes[4] = '{CMD_IOUT, CMD_TEMP, CMD_COMM_MEM, CMD_INPUT};
    psab_byte_t sups[4] = '{SUP_IOUT, SUP_TEMP, SUP_COMM_MEM, SUP_INPUT};
    psab_byte_t keep[4] = '{8'h00, 8'h00, 8'h00, 8'h2A};
    for (int i = 0; i < 4; i++)
    begin
      pulse(codes[i], 1'b1, 8'hFF);
      rdchk("set", codes[i], 1'b1, {8'h00, sups[i]});
      alert(1'b0);
      host.op(0, codes[i], 1'b1, 8'hFF);
      rdchk("one-write", codes[i], 1'b1, {8'h00, keep[i]});
      alert(1'b1);
      host.op(2, 8'h00, 1'b0, 8'h00);
      rdchk("global clear", codes[i], 1'b1, 16'h0000);
    end
    pulse(CMD_INPUT, 1'b0, 8'h2A);
    alert(1'b1);
    host.op(2, 8'h00, 1'b0, 8'h00);
    $display("test status bytes done");
  endtask

  task automatic t_mfr();
    pulse(CMD_MFR, 1'b0, 8'hFF);
    rdchk("vendor page0", CMD_MFR, 1'b0, 16'h00FE);
    rdchk("vendor page1", CMD_MFR, 1'b1, 16'h00FE);
    chk("mfrSummary", 16'h0003, {14'h0000, mfrSummary});
    alert(1'b0);
    host.op(0, CMD_MFR, 1'b0, 8'hFF);
    rdchk("vendor one-write", CMD_MFR, 1'b0, 16'h0008);
    alert(1'b0);
    host.op(2, 8'h00, 1'b0, 8'h00);
    rdchk("log bit after clear", CMD_MFR, 1'b0, 16'h0008);
    alert(1'b0);
    host.op(3, CMD_MFR, 1'b0, 8'h00);
    rdchk("vendor log clear", CMD_MFR, 1'b0, 16'h0000);
    alert(1'b1);
    chk("mfrSummary", 16'h0000, {14'h0000, mfrSummary});
    pulse(8'h00, 1'b1, 8'h01);
    rdchk("pin bit page1", CMD_MFR, 1'b1, 16'h0001);
    rdchk("pin bit page0", CMD_MFR, 1'b0, 16'h0000);
    chk("mfrSummary", 16'h0002, {14'h0000, mfrSummary});
    alert(1'b1);
    host.op(0, CMD_MFR, 1'b1, 8'h01);
    rdchk("pin bit cleared", CMD_MFR, 1'b1, 16'h0000);
    pulse(CMD_MFR, 1'b0, 8'h10);
    alert(1'b1);
    host.op(2, 8'h00, 1'b0, 8'h00);
    $display("test vendor byte done");
  endtask

  task automatic t_mask();
    host.op(1, CMD_TEMP, 1'b0, 8'h40);
    pulse(CMD_TEMP, 1'b0, 8'h40);
    rdchk("masked bit", CMD_TEMP, 1'b0, 16'h0040);
    alert(1'b1);
    pulse(CMD_TEMP, 1'b0, 8'h80);
    alert(1'b0);
    host.op(2, 8'h00, 1'b0, 8'h00);
    alert(1'b1);
    host.op(1, CMD_MFR, 1'b1, 8'h00);
    pulse(8'h00, 1'b1, 8'h01);
    alert(1'b0);
    host.op(2, 8'h00, 1'b0, 8'h00);
    $display("test alert mask done");
  endtask

  task automatic t_persist();
    setc(CMD_VOUT, 1'b0, 8'h80);
    host.op(0, CMD_VOUT, 1'b0, 8'h80);
    rdchk("held fault", CMD_VOUT, 1'b0, 16'h0080);
    host.op(2, 8'h00, 1'b0, 8'h00);
    rdchk("held after clear", CMD_VOUT, 1'b0, 16'h0080);
    alert(1'b0);
    setc(CMD_VOUT, 1'b0, 8'h00);
    rdchk("latched", CMD_VOUT, 1'b0, 16'h0080);
    host.op(2, 8'h00, 1'b0, 8'h00);
    rdchk("released", CMD_VOUT, 1'b0, 16'h0000);
    alert(1'b1);
    $display("test persistence done");
  endtask

  task automatic t_ro();
    rdchk("pad word", CMD_PADS, 1'b0, 16'hCFEE);
    host.op(0, CMD_PADS, 1'b0, 8'hFF);
    rdchk("pad word", CMD_PADS, 1'b0, 16'hCFEE);
    rdchk("common byte", CMD_COMMON, 1'b0, 16'h00FB);
    pulse(CMD_VOUT, 1'b0, 8'h80);
    rdchk("common byte alert", CMD_COMMON, 1'b0, 16'h007B);
    host.op(2, 8'h00, 1'b0, 8'h00);
    // Mixed levels so that a swapped field shows up
    @(posedge clock);
    padInternal <= 16'h4A96;
    padPinsRaw <= 4'h5;
    writeProtectPinRaw <= 1'b0;
    commonIn <= 5'h12;
    rdchk("pad word mixed", CMD_PADS, 1'b0, 16'h4A95);
    rdchk("common byte mixed", CMD_COMMON, 1'b0, 16'h00C8);
    $display("test read-only words done");
  endtask

  // Main sequence
  initial
  begin
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    t_reset();
    t_vout();
    t_bytes();
    t_mfr();
    t_mask();
    t_persist();
    t_ro();
    complete_run();
  end
endmodule
